// File: brr_pkg.sv
// Constants, register map and types for the byte rotate unit.
// Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
// Functional notes
// - Rotate left no carry: bits move up, bit 7 wraps to 0, C is kept.
// - Rotate right via carry: bits move down, C into 7, bit 0 into C.
// - Rotate right no carry: bits move down, bit 0 into 7, only N, Z.
// - Destination 0 writes W; 1, the default, writes the file register.
// - Access 0 uses the access bank; 1 (default) uses the bank select.
// - Access 0, extended set on and address up to 5Fh use indexed offset.
// - One rotate is one instruction cycle: decode, read, compute, write.
// - Via carry updates C, N and Z; left no carry updates only N and Z.
// - Rotate left no carry takes source bit 7 into result bit 0.
package brr_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BANK   = 8'h04;
  localparam logic [7:0] ADDR_WREG   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INDEX  = 8'h10;
  localparam logic [7:0] ADDR_MADDR  = 8'h14;
  localparam logic [7:0] ADDR_MDATA  = 8'h18;

  // Field positions.
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_DEST    = 2;
  localparam int CTRL_ACC     = 3;
  localparam int CTRL_EXT     = 4;
  localparam int CTRL_F_LSB   = 8;
  localparam int CTRL_GO      = 31;
  localparam int STAT_C       = 0;
  localparam int STAT_N       = 1;
  localparam int STAT_Z       = 2;
  localparam int STAT_BUSY    = 8;

  // Values after reset.
  localparam logic [1:0]  OP_RST   = 2'h0;
  localparam logic        DEST_RST = 1'h1;
  localparam logic        ACC_RST  = 1'h1;
  localparam logic        EXT_RST  = 1'h0;
  localparam logic [7:0]  F_RST    = 8'h00;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;

  // Access bank layout and the indexed literal offset limit.
  localparam logic [7:0] ACC_LIMIT = 8'h5F;
  localparam logic [3:0] ACC_LO    = 4'h0;
  localparam logic [3:0] ACC_HI    = 4'hF;

  // Operation codes.
  localparam logic [1:0] OP_RLNC = 2'h0;
  localparam logic [1:0] OP_RRC  = 2'h1;
  localparam logic [1:0] OP_RRNC = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4} brr_state_t;

endpackage : brr_pkg

// File: brr_rotate_unit.sv
// Byte rotate execution unit with its own file memory and AHB-Lite slave.
// Assumes a single AHB-Lite master doing single word transfers.
module brr_rotate_unit #(
  parameter int AW = 12
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  logic [1:0]  op_q, op_d;
  logic        dest_q, dest_d, acc_q, acc_d, ext_q, ext_d;
  logic [7:0]  f_q, f_d;
  logic [3:0]  bank_q, bank_d;
  logic [7:0]  wreg_q, wreg_d, opnd_q, opnd_d, res_q, res_d;
  logic        c_q, c_d, n_q, n_d, z_q, z_d;
  logic [11:0] ibase_q, ibase_d, maddr_q, maddr_d;
  logic [AW-1:0] ea_q, ea_d;
  brr_pkg::brr_state_t st_q, st_d;
  logic        ap_q, ap_d, apw_q, apw_d, rdy_q, rdy_d;
  logic [7:0]  apa_q, apa_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0]  mem_q [0:(1<<AW)-1];
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;
  logic          go_fire;

  assign hreadyout = rdy_q;
  assign hrdata    = rd_q;
  assign hresp     = 1'b0;

  always_comb begin
    op_d = op_q; dest_d = dest_q; acc_d = acc_q; ext_d = ext_q;
    f_d = f_q; bank_d = bank_q; wreg_d = wreg_q; opnd_d = opnd_q;
    res_d = res_q; c_d = c_q; n_d = n_q; z_d = z_q;
    ibase_d = ibase_q; maddr_d = maddr_q; ea_d = ea_q; st_d = st_q;
    ap_d = ap_q; apw_d = apw_q; apa_d = apa_q; rdy_d = rdy_q;
    rd_d = rd_q; mem_we = 1'b0; mem_wa = ea_q; mem_wd = res_q;
    go_fire = 1'b0;
    // Bus: a data phase waits while an instruction is in flight.
    if (ap_q && st_q == brr_pkg::ST_IDLE) begin
      ap_d  = 1'b0;
      rdy_d = 1'b1;
      rd_d  = 32'h00000000;
      if (apw_q) begin
        case (apa_q)
          brr_pkg::ADDR_CTRL: begin
            op_d   = hwdata[brr_pkg::CTRL_OP_LSB +: 2];
            dest_d = hwdata[brr_pkg::CTRL_DEST];
            acc_d  = hwdata[brr_pkg::CTRL_ACC];
            ext_d  = hwdata[brr_pkg::CTRL_EXT];
            f_d    = hwdata[brr_pkg::CTRL_F_LSB +: 8];
            if (hwdata[brr_pkg::CTRL_GO] &&
                hwdata[brr_pkg::CTRL_OP_LSB +: 2] != 2'h3) begin
              go_fire = 1'b1;
              st_d    = brr_pkg::ST_Q1;
            end
          end
          brr_pkg::ADDR_BANK:  bank_d = hwdata[3:0];
          brr_pkg::ADDR_WREG:  wreg_d = hwdata[7:0];
          brr_pkg::ADDR_STATUS: begin
            c_d = hwdata[brr_pkg::STAT_C];
            n_d = hwdata[brr_pkg::STAT_N];
            z_d = hwdata[brr_pkg::STAT_Z];
          end
          brr_pkg::ADDR_INDEX: ibase_d = hwdata[11:0];
          brr_pkg::ADDR_MADDR: maddr_d = hwdata[11:0];
          brr_pkg::ADDR_MDATA: begin
            mem_we = 1'b1;
            mem_wa = maddr_q[AW-1:0];
            mem_wd = hwdata[7:0];
          end
          default: ;
        endcase
      end else begin
        case (apa_q)
          brr_pkg::ADDR_CTRL: begin
            rd_d[brr_pkg::CTRL_OP_LSB +: 2] = op_q;
            rd_d[brr_pkg::CTRL_DEST] = dest_q;
            rd_d[brr_pkg::CTRL_ACC]  = acc_q;
            rd_d[brr_pkg::CTRL_EXT]  = ext_q;
            rd_d[brr_pkg::CTRL_F_LSB +: 8] = f_q;
          end
          brr_pkg::ADDR_BANK: rd_d[3:0] = bank_q;
          brr_pkg::ADDR_WREG: rd_d[7:0] = wreg_q;
          brr_pkg::ADDR_STATUS: begin
            rd_d[brr_pkg::STAT_C] = c_q;
            rd_d[brr_pkg::STAT_N] = n_q;
            rd_d[brr_pkg::STAT_Z] = z_q;
          end
          brr_pkg::ADDR_INDEX: rd_d[11:0] = ibase_q;
          brr_pkg::ADDR_MADDR: rd_d[11:0] = maddr_q;
          brr_pkg::ADDR_MDATA: rd_d[7:0]  = mem_q[maddr_q[AW-1:0]];
          default: ;
        endcase
      end
    end else if (!ap_q && hsel && htrans[1] && hready) begin
      ap_d  = 1'b1;
      apw_d = hwrite;
      apa_d = haddr[7:0];
      rdy_d = 1'b0;
    end
    // Instruction engine, one state per quarter cycle.
    case (st_q)
      brr_pkg::ST_IDLE: ;
      brr_pkg::ST_Q1: begin
        if (acc_q) begin
          ea_d = AW'({bank_q, f_q});
        end else if (ext_q && f_q <= brr_pkg::ACC_LIMIT) begin
          ea_d = AW'(ibase_q + {4'h0, f_q});
        end else if (f_q <= brr_pkg::ACC_LIMIT) begin
          ea_d = AW'({brr_pkg::ACC_LO, f_q});
        end else begin
          ea_d = AW'({brr_pkg::ACC_HI, f_q});
        end
        st_d = brr_pkg::ST_Q2;
      end
      brr_pkg::ST_Q2: begin
        opnd_d = mem_q[ea_q];
        st_d   = brr_pkg::ST_Q3;
      end
      brr_pkg::ST_Q3: begin
        case (op_q)
          brr_pkg::OP_RLNC: begin
            res_d = {opnd_q[6:0], opnd_q[7]};
          end
          brr_pkg::OP_RRC: begin
            res_d = {c_q, opnd_q[7:1]};
            c_d   = opnd_q[0];
          end
          default: res_d = {opnd_q[0], opnd_q[7:1]};
        endcase
        n_d  = res_d[7];
        z_d  = (res_d == 8'h00);
        st_d = brr_pkg::ST_Q4;
      end
      brr_pkg::ST_Q4: begin
        if (dest_q) begin
          mem_we = 1'b1;
        end else begin
          wreg_d = res_q;
        end
        st_d = brr_pkg::ST_IDLE;
      end
      default: st_d = brr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_q <= brr_pkg::OP_RST; dest_q <= brr_pkg::DEST_RST;
      acc_q <= brr_pkg::ACC_RST; ext_q <= brr_pkg::EXT_RST;
      f_q <= brr_pkg::F_RST; bank_q <= brr_pkg::BANK_RST;
      wreg_q <= brr_pkg::BYTE_RST; opnd_q <= brr_pkg::BYTE_RST;
      res_q <= brr_pkg::BYTE_RST;
      c_q <= 1'b0; n_q <= 1'b0; z_q <= 1'b0;
      ibase_q <= brr_pkg::ADDR_RST; maddr_q <= brr_pkg::ADDR_RST;
      ea_q <= '0; st_q <= brr_pkg::ST_IDLE;
      ap_q <= 1'b0; apw_q <= 1'b0; apa_q <= 8'h00;
      rdy_q <= 1'b1; rd_q <= 32'h00000000;
    end else begin
      op_q <= op_d; dest_q <= dest_d; acc_q <= acc_d; ext_q <= ext_d;
      f_q <= f_d; bank_q <= bank_d; wreg_q <= wreg_d; opnd_q <= opnd_d;
      res_q <= res_d; c_q <= c_d; n_q <= n_d; z_q <= z_d;
      ibase_q <= ibase_d; maddr_q <= maddr_d; ea_q <= ea_d; st_q <= st_d;
      ap_q <= ap_d; apw_q <= apw_d; apa_q <= apa_d;
      rdy_q <= rdy_d; rd_q <= rd_d;
    end
  end

  // The file memory has no reset; software loads it through the window.
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_qcycle;
    st_q == brr_pkg::ST_Q1 ##1 st_q == brr_pkg::ST_Q2 ##1
    st_q == brr_pkg::ST_Q3 ##1 st_q == brr_pkg::ST_Q4 ##1
    st_q == brr_pkg::ST_IDLE;
  endsequence

  property p_rlnc;
    (st_q == brr_pkg::ST_Q3 && op_q == brr_pkg::OP_RLNC) |=>
      res_q == {$past(opnd_q[6:0]), $past(opnd_q[7])} && c_q == $past(c_q);
  endproperty
  a_rlnc: assert property (p_rlnc)
    else $error("rotate left bad");

  property p_rlnc_wrap;
    (st_q == brr_pkg::ST_Q3 && op_q == brr_pkg::OP_RLNC) |=>
      res_q[0] == $past(opnd_q[7]);
  endproperty
  a_rlnc_wrap: assert property (p_rlnc_wrap)
    else $error("bit 7 lost");

  property p_rrc;
    (st_q == brr_pkg::ST_Q3 && op_q == brr_pkg::OP_RRC) |=>
      res_q == {$past(c_q), $past(opnd_q[7:1])} && c_q == $past(opnd_q[0]);
  endproperty
  a_rrc: assert property (p_rrc)
    else $error("rotate via carry bad");

  property p_rrnc;
    (st_q == brr_pkg::ST_Q3 && op_q == brr_pkg::OP_RRNC) |=>
      res_q == {$past(opnd_q[0]), $past(opnd_q[7:1])} && $stable(c_q);
  endproperty
  a_rrnc: assert property (p_rrnc)
    else $error("rotate right bad");

  property p_dest;
    (st_q == brr_pkg::ST_Q4 && !dest_q) |=> wreg_q == $past(res_q);
  endproperty
  a_dest: assert property (p_dest)
    else $error("W not written");

  property p_bank;
    (st_q == brr_pkg::ST_Q1 && acc_q) |=>
      ea_q == AW'({$past(bank_q), $past(f_q)});
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank address bad");

  property p_index;
    (st_q == brr_pkg::ST_Q1 && !acc_q && ext_q && f_q <= brr_pkg::ACC_LIMIT)
      |=> ea_q == AW'($past(ibase_q) + {4'h0, $past(f_q)});
  endproperty
  a_index: assert property (p_index)
    else $error("indexed address bad");

  property p_qcycle;
    go_fire |=> s_qcycle;
  endproperty
  a_qcycle: assert property (p_qcycle)
    else $error("Q sequence bad");

  property p_flags;
    st_q == brr_pkg::ST_Q3 |=> n_q == res_q[7] && z_q == (res_q == 8'h00);
  endproperty
  a_flags: assert property (p_flags)
    else $error("N or Z bad");

  property p_busy_stall;
    (ap_q && st_q != brr_pkg::ST_IDLE) |-> !rdy_q;
  endproperty
  a_busy_stall: assert property (p_busy_stall)
    else $error("ready while busy");

endmodule : brr_rotate_unit

// File: brr_core_model.sv
// Reference model of the core's rotate datapath, used by the bench.
// Assumes the operation codes of brr_pkg; purely combinational.
module brr_core_model (
  // Operation and operands.
  input  wire logic [1:0] op,
  input  wire logic [7:0] src,
  input  wire logic       cin,
  // Result and flags as STATUS shows them.
  output logic      [7:0] res,
  output logic            cout,
  output logic      [2:0] flags
);
  always_comb begin
    res = {src[6:0], src[7]};
    cout = cin;
    if (op == brr_pkg::OP_RRC) begin
      res = {cin, src[7:1]};
      cout = src[0];
    end else if (op == brr_pkg::OP_RRNC) begin
      res = {src[0], src[7:1]};
    end
    flags = {res == 8'h00, res[7], cout};
  end
endmodule : brr_core_model

// File: brr_rotate_unit_tb_top.sv
// Self-checking bench for the byte rotate unit, acting as AHB-Lite master.
// Assumes the register map of brr_pkg and one slave whose hreadyout is hready.
module brr_rotate_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] v;} brr_note_t;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp;
  logic        rd_pend = 1'b0;
  logic [1:0]  htrans, op;
  logic [2:0]  hsize, flags;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  src, f, res;
  logic        cin, cout, dst, acc, ext;
  logic [3:0]  bank;
  logic [11:0] idx, ea;
  brr_note_t   notes[$];
  int          n_fail = 0, checks_done = 0, cycles = 0, seed = 179;

  brr_rotate_unit dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  brr_core_model ref_m (.op(op), .src(src), .cin(cin), .res(res),
    .cout(cout), .flags(flags));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // One single transfer; every wait ends only on hready seen high.
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
  endtask : bus

  task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
    notes.push_back('{nm, exp});
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Read data phases complete on hready high; compare with the oldest note.
  always @(posedge clock) begin
    cycles++;
    if (hreadyout === 1'b1 && rd_pend) begin
      if (notes.size() == 0) check("queue", 32'h1, 32'h0);
      else check(notes[0].nm, hrdata, notes[0].v);
      check("hresp", {31'h0, hresp}, 32'h0);
      if (notes.size() != 0) void'(notes.pop_front());
    end
    if (hreadyout === 1'b1) rd_pend = htrans[1] && !hwrite;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    op = 2'h0;
    src = 8'h00;
    cin = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(brr_pkg::ADDR_CTRL, 32'h0000000C, "ctrl");
    rd(8'h40, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      op = 2'(i % 3);
      src = 8'($random(seed));
      if (i % 7 == 6) src = 8'h00;
      cin = 1'($random(seed));
      {dst, acc, ext} = 3'($random(seed));
      f = 8'($random(seed));
      if (i < 6) f = 8'h5F + 8'(i % 2);
      bank = 4'($random(seed));
      idx = 12'($random(seed));
      ea = acc ? {bank, f} : (f > 8'h5F) ? {4'hF, f} :
        ext ? idx + 12'(f) : {4'h0, f};
      bus(1'b1, brr_pkg::ADDR_BANK, {28'h0, bank});
      bus(1'b1, brr_pkg::ADDR_INDEX, {20'h0, idx});
      bus(1'b1, brr_pkg::ADDR_MADDR, {20'h0, ea});
      bus(1'b1, brr_pkg::ADDR_MDATA, {24'h0, src});
      bus(1'b1, brr_pkg::ADDR_STATUS, {31'h0, cin});
      bus(1'b1, brr_pkg::ADDR_WREG, 32'h0000005A);
      bus(1'b1, brr_pkg::ADDR_CTRL, {1'b1, 15'h0, f, 3'h0, ext, acc, dst, op});
      rd(brr_pkg::ADDR_WREG, dst ? 32'h5A : {24'h0, res},
         "wreg");
      rd(brr_pkg::ADDR_MDATA, {24'h0, dst ? res : src},
         "file");
      rd(brr_pkg::ADDR_STATUS, {29'h0, flags},
         "status");
    end
    $display("test rotate done");
    // A go with the unused operation code must leave the file byte alone.
    bus(1'b1, brr_pkg::ADDR_BANK, 32'h00000000);
    bus(1'b1, brr_pkg::ADDR_MADDR, 32'h000000AA);
    bus(1'b1, brr_pkg::ADDR_MDATA, 32'h00000081);
    bus(1'b1, brr_pkg::ADDR_CTRL, 32'h8000AA0F);
    rd(brr_pkg::ADDR_MDATA, 32'h00000081, "op3 file");
    rd(brr_pkg::ADDR_CTRL, 32'h0000AA0F, "op3 ctrl");
    $display("test refused code done");
    repeat (2) @(posedge clock);
    finish_test();
  end
endmodule : brr_rotate_unit_tb_top
